/* File: design/svb_bank.sv */
// configuration and interrupt enable bank of the window supervisor
`timescale 1ns/100ps
module svb_bank (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       otp_load,
   input  wire logic [1:0] otp_selftest_on_powerup,
   input  wire logic       pkt_done,
   input  wire logic       pkt_has_check,
   input  wire logic       pkt_check_ok,
   input  wire logic       activity_input,
   input  wire logic       sleep_input,
   input  wire logic [7:0] uv_fast_evt,
   input  wire logic [7:0] uv_slow_evt,
   input  wire logic [7:0] ov_fast_evt,
   input  wire logic [7:0] ov_slow_evt,
   input  wire logic [5:0] seq_on_evt,
   input  wire logic [5:0] seq_off_evt,
   input  wire logic [5:0] wake_evt,
   input  wire logic [5:0] doze_evt,
   input  wire logic       crc_evt,
   input  wire logic       thermal_evt,
   input  wire logic       sync_short_evt,
   input  wire logic       ecc_fix_evt,
   input  wire logic       selftest_fail_evt,
   input  wire logic       status_clear,
   output logic            interrupt_out_n,
   output logic            packet_fault,
   output logic            selftest_start,
   output logic            selftest_ready,
   output logic            config_corrupt,
   output logic      [7:0] monitor_run,
   output logic      [7:0] range_4x,
   output logic      [7:0] ch1_uv_fast_code,
   output logic     [12:0] ch1_uv_fast_mv
);
   logic [7:0]  misc;
   logic [7:0]  selftest_run_config;
   logic [7:0]  ien_uvf;
   logic [7:0]  ien_uvs;
   logic [7:0]  ien_ovf;
   logic [7:0]  ien_ovs;
   logic [7:0]  ien_son;
   logic [7:0]  ien_soff;
   logic [7:0]  ien_wake;
   logic [7:0]  ien_doze;
   logic [7:0]  ien_ctrl;
   logic [7:0]  irq_enable_test_faults;
   logic [7:0]  mon_en;
   logic [7:0]  range_sel;
   logic [7:0]  ch1_uvf;
   logic        wr_hit;
   logic [7:0]  wd;
   logic        pkt_bad;
   logic        act_q;
   logic        act_fall;
   logic        por_pending;
   logic        fire;
   logic        t_ready;
   logic        t_done;
   logic [31:0] volt_set;
   logic [31:0] volt_en;
   logic [23:0] seq_set;
   logic [23:0] seq_en;
   logic [6:0]  misc_set;
   logic [6:0]  misc_en;
   logic        pend_v;
   logic        pend_s;
   logic        pend_m;

   assign wr_hit = reg_wr;
   assign wd     = reg_wdata;

   // register writes; masks keep reserved positions at zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         misc      <= svb_pkg::RST_MISC;
         ien_uvf   <= svb_pkg::RST_ZERO;
         ien_uvs   <= svb_pkg::RST_ZERO;
         ien_ovf   <= svb_pkg::RST_ZERO;
         ien_ovs   <= svb_pkg::RST_ZERO;
         ien_son   <= svb_pkg::RST_ZERO;
         ien_soff  <= svb_pkg::RST_ZERO;
         ien_wake  <= svb_pkg::RST_ZERO;
         ien_doze  <= svb_pkg::RST_ZERO;
         ien_ctrl  <= svb_pkg::RST_ZERO;
         irq_enable_test_faults <= svb_pkg::RST_ZERO;
         mon_en    <= svb_pkg::RST_ZERO;
         range_sel <= svb_pkg::RST_ZERO;
         ch1_uvf   <= svb_pkg::RST_ZERO;
      end else if (wr_hit) begin
         case (reg_addr)
            svb_pkg::ADDR_MISC:     misc      <= wd & svb_pkg::MASK_MISC;
            svb_pkg::ADDR_IEN_UVF:  ien_uvf   <= wd & svb_pkg::MASK_CH8;
            svb_pkg::ADDR_IEN_UVS:  ien_uvs   <= wd & svb_pkg::MASK_CH8;
            svb_pkg::ADDR_IEN_OVF:  ien_ovf   <= wd & svb_pkg::MASK_CH8;
            svb_pkg::ADDR_IEN_OVS:  ien_ovs   <= wd & svb_pkg::MASK_CH8;
            svb_pkg::ADDR_IEN_SON:  ien_son   <= wd & svb_pkg::MASK_CH6;
            svb_pkg::ADDR_IEN_SOFF: ien_soff  <= wd & svb_pkg::MASK_CH6;
            svb_pkg::ADDR_IEN_WAKE: ien_wake  <= wd & svb_pkg::MASK_CH6;
            svb_pkg::ADDR_IEN_DOZE: ien_doze  <= wd & svb_pkg::MASK_CH6;
            svb_pkg::ADDR_IEN_CTRL: ien_ctrl  <= wd & svb_pkg::MASK_CTRL;
            svb_pkg::ADDR_IEN_DIAG: irq_enable_test_faults <= wd & svb_pkg::MASK_TEST;
            svb_pkg::ADDR_MON_EN:   mon_en    <= wd;
            svb_pkg::ADDR_RANGE:    range_sel <= wd;
            svb_pkg::ADDR_CH1_UVF:  ch1_uvf   <= wd;
            default: ;
         endcase
      end
   end

   // one-time memory load wins over a bus write in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         selftest_run_config <= svb_pkg::RST_ZERO;
      end else if (otp_load) begin
         selftest_run_config <= {6'h00, otp_selftest_on_powerup} & svb_pkg::MASK_OTP_CFG;
      end else if (wr_hit && reg_addr == svb_pkg::ADDR_SELFTEST) begin
         selftest_run_config <= wd & svb_pkg::MASK_SELFTEST;
      end
   end

   // registered read port; unmapped and vendor addresses read zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= svb_pkg::RST_ZERO;
      end else if (reg_rd) begin
         case (reg_addr)
            svb_pkg::ADDR_MISC:     reg_rdata <= misc;
            svb_pkg::ADDR_SELFTEST: reg_rdata <= selftest_run_config;
            svb_pkg::ADDR_IEN_UVF:  reg_rdata <= ien_uvf;
            svb_pkg::ADDR_IEN_UVS:  reg_rdata <= ien_uvs;
            svb_pkg::ADDR_IEN_OVF:  reg_rdata <= ien_ovf;
            svb_pkg::ADDR_IEN_OVS:  reg_rdata <= ien_ovs;
            svb_pkg::ADDR_IEN_SON:  reg_rdata <= ien_son;
            svb_pkg::ADDR_IEN_SOFF: reg_rdata <= ien_soff;
            svb_pkg::ADDR_IEN_WAKE: reg_rdata <= ien_wake;
            svb_pkg::ADDR_IEN_DOZE: reg_rdata <= ien_doze;
            svb_pkg::ADDR_IEN_CTRL: reg_rdata <= ien_ctrl;
            svb_pkg::ADDR_IEN_DIAG: reg_rdata <= irq_enable_test_faults;
            svb_pkg::ADDR_MON_EN:   reg_rdata <= mon_en;
            svb_pkg::ADDR_RANGE:    reg_rdata <= range_sel;
            svb_pkg::ADDR_CH1_UVF:  reg_rdata <= ch1_uvf;
            default:                reg_rdata <= svb_pkg::RST_ZERO;
         endcase
      end
   end

   // packet check verdict, only meaningful while checking is on
   always_comb begin
      pkt_bad = 1'b0;
      if (pkt_done && misc[svb_pkg::BIT_PEC_ON]) begin
         if (pkt_has_check) begin
            pkt_bad = !pkt_check_ok;
         end else begin
            pkt_bad = misc[svb_pkg::BIT_REQ_CHECK];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         packet_fault <= 1'b0;
      end else begin
         packet_fault <= pkt_bad;
      end
   end

   // self-test launch: power-up decision at load, or activity falling
   assign act_fall = act_q && !activity_input;
   assign fire = (por_pending && otp_load && otp_selftest_on_powerup != svb_pkg::POR_SKIP)
              || (act_fall && selftest_run_config[svb_pkg::BIT_SHDN_TEST]);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         act_q          <= 1'b0;
         por_pending    <= 1'b1;
         selftest_start <= 1'b0;
         selftest_ready <= 1'b0;
         config_corrupt <= 1'b0;
      end else begin
         act_q          <= activity_input;
         selftest_start <= fire;
         // ready is withheld until the first configuration load
         selftest_ready <= t_ready && !fire && !por_pending;
         config_corrupt <= selftest_run_config[svb_pkg::POR_HI:0] == svb_pkg::POR_CORRUPT_A
            || selftest_run_config[svb_pkg::POR_HI:0] == svb_pkg::POR_CORRUPT_B;
         if (otp_load) begin
            por_pending <= 1'b0;
         end
      end
   end

   svb_wait_timer #(
      .CYC   (svb_pkg::CFG_WAIT_CYC)
   ) u_wait (
      .clk   (clk),
      .rst_n (rst_n),
      .start (fire),
      .ready (t_ready),
      .done  (t_done)
   );

   // disabled channels cannot raise voltage faults
   assign volt_set = {ov_slow_evt, ov_fast_evt, uv_slow_evt, uv_fast_evt}
                   & {4{mon_en}};
   assign volt_en  = {ien_ovs,
                      ien_ovf,
                      ien_uvs,
                      ien_uvf};

   // order faults counted only in the phase their edge opens
   assign seq_set = {doze_evt & {6{!sleep_input}},
                     wake_evt & {6{sleep_input}},
                     seq_off_evt & {6{!activity_input}},
                     seq_on_evt & {6{activity_input}}};
   assign seq_en  = {ien_doze[5:0],
                     ien_wake[5:0],
                     ien_soff[5:0],
                     ien_son[5:0]};

   // completion and failure keep separate flags so each enable gates only its own
   assign misc_set = {crc_evt, thermal_evt, sync_short_evt, pkt_bad,
                      ecc_fix_evt, t_done, selftest_fail_evt};
   assign misc_en  = {ien_ctrl[svb_pkg::CTRL_CRC],
                      ien_ctrl[svb_pkg::CTRL_THERMAL],
                      ien_ctrl[svb_pkg::CTRL_SYNC],
                      ien_ctrl[svb_pkg::CTRL_PKT],
                      irq_enable_test_faults[svb_pkg::TEST_ECC],
                      irq_enable_test_faults[svb_pkg::TEST_DONE],
                      irq_enable_test_faults[svb_pkg::TEST_FAIL]};

   svb_flags #(.W(32)) u_volt (
      .clk   (clk),
      .rst_n (rst_n),
      .set   (volt_set),
      .clr   (status_clear),
      .en    (volt_en),
      .flags (),
      .pend  (pend_v)
   );

   svb_flags #(.W(24)) u_seq (
      .clk   (clk),
      .rst_n (rst_n),
      .set   (seq_set),
      .clr   (status_clear),
      .en    (seq_en),
      .flags (),
      .pend  (pend_s)
   );

   svb_flags #(.W(7)) u_misc (
      .clk   (clk),
      .rst_n (rst_n),
      .set   (misc_set),
      .clr   (status_clear),
      .en    (misc_en),
      .flags (),
      .pend  (pend_m)
   );

   // a registered pin avoids glitches from the enable gating
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_out_n <= 1'b1;
      end else begin
         interrupt_out_n <= !(pend_v || pend_s || pend_m);
      end
   end

   // channel controls and threshold in millivolts
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         monitor_run      <= svb_pkg::RST_ZERO;
         range_4x         <= svb_pkg::RST_ZERO;
         ch1_uv_fast_code <= svb_pkg::RST_ZERO;
         ch1_uv_fast_mv   <= svb_pkg::BASE_1X_MV;
      end else begin
         monitor_run      <= mon_en;
         range_4x         <= range_sel;
         ch1_uv_fast_code <= ch1_uvf;
         if (range_sel[0]) begin
            ch1_uv_fast_mv <= svb_pkg::BASE_4X_MV + {5'h00, ch1_uvf} * svb_pkg::STEP_4X_MV;
         end else begin
            ch1_uv_fast_mv <= svb_pkg::BASE_1X_MV + {5'h00, ch1_uvf} * svb_pkg::STEP_1X_MV;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_PKT_OFF: assert property (
      pkt_done && !misc[svb_pkg::BIT_PEC_ON] |=> !packet_fault)
      else $error("packet fault raised while checking off");
   AST_PKT_MISSING: assert property (
      pkt_done && misc[svb_pkg::BIT_PEC_ON] && misc[svb_pkg::BIT_REQ_CHECK]
      && !pkt_has_check |=> packet_fault)
      else $error("missing check byte not flagged");
   AST_SHDN_START: assert property (
      $fell(activity_input) && $past(act_q) && selftest_run_config[svb_pkg::BIT_SHDN_TEST]
      |=> selftest_start)
      else $error("shutdown self-test not started");
   AST_READY_WAIT: assert property (
      selftest_start |-> !selftest_ready [*8])
      else $error("ready before configuration wait");
   AST_OTP_CLEARS: assert property (
      otp_load |=> !selftest_run_config[svb_pkg::BIT_SHDN_TEST])
      else $error("shutdown bit survived configuration load");
   AST_POR_DECODE: assert property (
      selftest_run_config[svb_pkg::POR_HI:0] == svb_pkg::POR_CORRUPT_B |=> config_corrupt)
      else $error("corrupt power-up code not reported");
   AST_UVF_IRQ: assert property (
      uv_fast_evt[7] && ien_uvf[7] && mon_en[7] |-> ##2 !interrupt_out_n)
      else $error("enabled fast undervoltage did not interrupt");
   AST_MASKED: assert property (
      (volt_en == '0 && seq_en == '0 && misc_en == '0) |=> interrupt_out_n)
      else $error("interrupt with every source disabled");
   AST_RSVD_READ: assert property (
      reg_rd && reg_addr == svb_pkg::ADDR_IEN_SON |=> reg_rdata[7:6] == 2'h0)
      else $error("reserved bits read nonzero");
   AST_MV_1X: assert property (
      !range_sel[0] && ch1_uvf == svb_pkg::RST_ZERO |=> ch1_uv_fast_mv == svb_pkg::BASE_1X_MV)
      else $error("threshold base wrong");

   COV_SELFTEST: cover property (selftest_start ##1 !selftest_ready);
   COV_IRQ: cover property ($fell(interrupt_out_n));
   COV_PKT: cover property (packet_fault);
endmodule : svb_bank

/* File: design/svb_flags.sv */
// sticky fault flags with enable gating onto one pending line
`timescale 1ns/100ps
module svb_flags #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] set,
   input  wire logic         clr,
   input  wire logic [W-1:0] en,
   output logic      [W-1:0] flags,
   output logic              pend
);
   // an event in the clearing cycle survives
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= '0;
      end else begin
         flags <= (clr ? '0 : flags) | set;
      end
   end

   assign pend = |(flags & en);
endmodule : svb_flags

/* File: design/svb_wait_timer.sv */
// self-test run timer that holds ready low for the configuration wait
`timescale 1ns/100ps
module svb_wait_timer #(
   parameter int CYC = 1
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic start,
   output logic      ready,
   output logic      done
);
   svb_pkg::svb_st_t st;
   logic [15:0]      cnt;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st    <= svb_pkg::ST_IDLE;
         cnt   <= 16'h0000;
         ready <= 1'b1;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         case (st)
            svb_pkg::ST_IDLE: begin
               if (start) begin
                  st    <= svb_pkg::ST_RUN;
                  cnt   <= 16'(CYC - 1);
                  ready <= 1'b0;
               end
            end
            svb_pkg::ST_RUN: begin
               if (cnt == 16'h0000) begin
                  st    <= svb_pkg::ST_IDLE;
                  ready <= 1'b1;
                  done  <= 1'b1;
               end else begin
                  cnt <= cnt - 16'h0001;
               end
            end
            default: st <= svb_pkg::ST_IDLE;
         endcase
      end
   end
endmodule : svb_wait_timer

/* File: inc/svb_pkg.sv */
// constants and types shared by the supervisor enable bank
package svb_pkg;
   localparam logic [7:0] ADDR_MISC      = 8'h11;
   localparam logic [7:0] ADDR_SELFTEST  = 8'h12;
   localparam logic [7:0] ADDR_IEN_UVF   = 8'h13;
   localparam logic [7:0] ADDR_IEN_UVS   = 8'h14;
   localparam logic [7:0] ADDR_IEN_OVF   = 8'h15;
   localparam logic [7:0] ADDR_IEN_OVS   = 8'h16;
   localparam logic [7:0] ADDR_IEN_SON   = 8'h17;
   localparam logic [7:0] ADDR_IEN_SOFF  = 8'h18;
   localparam logic [7:0] ADDR_IEN_WAKE  = 8'h19;
   localparam logic [7:0] ADDR_IEN_DOZE  = 8'h1a;
   localparam logic [7:0] ADDR_IEN_CTRL  = 8'h1b;
   localparam logic [7:0] ADDR_IEN_DIAG  = 8'h1c;
   localparam logic [7:0] ADDR_IEN_MAKER = 8'h1d;
   localparam logic [7:0] ADDR_MON_EN    = 8'h1e;
   localparam logic [7:0] ADDR_RANGE     = 8'h1f;
   localparam logic [7:0] ADDR_CH1_UVF   = 8'h20;

   localparam logic [7:0] MASK_MISC      = 8'h0f;
   localparam logic [7:0] MASK_SELFTEST  = 8'h0b;
   localparam logic [7:0] MASK_OTP_CFG   = 8'h03;
   localparam logic [7:0] MASK_CH8       = 8'hff;
   localparam logic [7:0] MASK_CH6       = 8'h3f;
   localparam logic [7:0] MASK_CTRL      = 8'h17;
   localparam logic [7:0] MASK_TEST      = 8'h0b;

   localparam logic [7:0] RST_MISC       = 8'h0c;
   localparam logic [7:0] RST_ZERO       = 8'h00;

   localparam int BIT_PEC_ON    = 0;
   localparam int BIT_REQ_CHECK = 1;
   localparam int BIT_SHDN_TEST = 3;
   localparam int POR_HI        = 1;
   localparam int CTRL_CRC      = 4;
   localparam int CTRL_THERMAL  = 2;
   localparam int CTRL_SYNC     = 1;
   localparam int CTRL_PKT      = 0;
   localparam int TEST_ECC      = 3;
   localparam int TEST_DONE     = 1;
   localparam int TEST_FAIL     = 0;

   localparam logic [1:0] POR_SKIP      = 2'h0;
   localparam logic [1:0] POR_CORRUPT_A = 2'h1;
   localparam logic [1:0] POR_CORRUPT_B = 2'h2;

   localparam int         MV_W        = 13;
   localparam logic [12:0] BASE_1X_MV = 13'h00c8;
   localparam logic [12:0] STEP_1X_MV = 13'h0005;
   localparam logic [12:0] BASE_4X_MV = 13'h0320;
   localparam logic [12:0] STEP_4X_MV = 13'h0014;

   localparam int CLK_PERIOD_NS = 50;
   localparam int CFG_WAIT_NS   = 10000;
   localparam int CFG_WAIT_CYC  = (CFG_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {ST_IDLE, ST_RUN} svb_st_t;
endpackage : svb_pkg

/* File: testbench/svb_host.sv */
// host controller model driving the register strobes
`timescale 1ns/100ps
module svb_host (
   input  wire logic       clk,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
      reg_rd    = 1'b0;
   end

   // strobe held until the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      // released data must not look like the last value
      reg_wdata <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask : rd
endmodule : svb_host

/* File: testbench/tb_svb_bank.sv */
// self-checking bench for the supervisor enable bank
`timescale 1ns/100ps
module tb_svb_bank;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, monitor_run, range_4x, ch1_uv_fast_code;
   logic        reg_wr, reg_rd, interrupt_out_n, packet_fault;
   logic        selftest_start, selftest_ready, config_corrupt;
   logic [12:0] ch1_uv_fast_mv;
   logic [1:0]  otp_selftest_on_powerup = 2'h0;
   logic        has = 1'b0;
   logic        ok = 1'b0;
   logic        act = 1'b0;
   logic        slp = 1'b0;
   logic [15:0] src = 16'h0000;
   int          mismatches = 0;
   int          checked = 0;
   // offset, enable that passes, enable that hides
   localparam logic [23:0] EV [13] = '{24'h13807f, 24'h14807f, 24'h15807f, 24'h16807f,
      24'h17201f, 24'h18201f, 24'h19201f, 24'h1a201f, 24'h1b1007, 24'h1b0413,
      24'h1b0215, 24'h1c0803, 24'h1c0108};
   localparam logic [7:0] MSK [17] = '{8'h0f, 8'h0b, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f,
      8'h3f, 8'h3f, 8'h3f, 8'h17, 8'h0b, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00};
   // packet cases: check config, has byte, byte good, fault expected
   localparam logic [10:0] PK [5] = '{11'h060, 11'h068, 11'h079, 11'h06d, 11'h07e};

   svb_host u_svb_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   svb_bank u_svb_bank (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .otp_load(src[15]), .otp_selftest_on_powerup(otp_selftest_on_powerup), .pkt_done(src[14]),
      .pkt_has_check(has), .pkt_check_ok(ok), .activity_input(act), .sleep_input(slp),
      .uv_fast_evt({src[0], 7'h00}), .uv_slow_evt({src[1], 7'h00}),
      .ov_fast_evt({src[2], 7'h00}), .ov_slow_evt({src[3], 7'h00}),
      .seq_on_evt({src[4], 5'h00}), .seq_off_evt({src[5], 5'h00}),
      .wake_evt({src[6], 5'h00}), .doze_evt({src[7], 5'h00}), .crc_evt(src[8]),
      .thermal_evt(src[9]), .sync_short_evt(src[10]), .ecc_fix_evt(src[11]),
      .selftest_fail_evt(src[12]), .status_clear(src[13]),
      .interrupt_out_n(interrupt_out_n), .packet_fault(packet_fault),
      .selftest_start(selftest_start), .selftest_ready(selftest_ready),
      .config_corrupt(config_corrupt), .monitor_run(monitor_run), .range_4x(range_4x),
      .ch1_uv_fast_code(ch1_uv_fast_code), .ch1_uv_fast_mv(ch1_uv_fast_mv));

   always #25 clk = ~clk;

   task automatic chk(input logic [12:0] got, input logic [12:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_svb_host.rd(a, d);
      chk({5'h00, d}, {5'h00, exp});
   endtask : rchk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   // one-cycle pulse on an event line, returns just after the taking edge
   task automatic pulse(input int k);
      @(posedge clk);
      src[k] <= 1'b1;
      @(posedge clk);
      src[k] <= 1'b0;
      #1;
   endtask : pulse

   task automatic wrap_up();
      if ((mismatches == 0) && (checked > 0)) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      wrap_up();
   end

   initial begin
      logic [7:0] a;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 17; i++) begin
         a = 8'h11 + 8'(i);
         rchk(a, (i == 0) ? 8'h0c : 8'h00);
         u_svb_host.wr(a, 8'hff);
         rchk(a, MSK[i]);
      end
      otp_selftest_on_powerup <= 2'h1;
      pulse(15);
      chk(13'(selftest_start), 13'h1);
      cyc(205);
      chk(13'(selftest_ready), 13'h1);
      rchk(8'h12, 8'h01);
      for (int v = 0; v < 4; v++) begin
         u_svb_host.wr(8'h12, 8'(v));
         cyc(2);
         chk(13'(config_corrupt), 13'((v == 1) || (v == 2)));
      end
      for (int i = 0; i < 16; i++) u_svb_host.wr(8'h11 + 8'(i), 8'h00);
      pulse(13);
      for (int i = 0; i < 5; i++) begin
         u_svb_host.wr(8'h11, PK[i][10:3]);
         has <= PK[i][2];
         ok  <= PK[i][1];
         pulse(14);
         chk(13'(packet_fault), 13'(PK[i][0]));
         cyc(1);
         chk(13'(packet_fault), 13'h0);
      end
      chk(13'(interrupt_out_n), 13'h1);
      u_svb_host.wr(8'h1b, 8'h01);
      cyc(2);
      chk(13'(interrupt_out_n), 13'h0);
      u_svb_host.wr(8'h1b, 8'h00);
      u_svb_host.wr(8'h20, 8'hff);
      cyc(2);
      chk(ch1_uv_fast_mv, 13'h05c3);
      chk(13'(ch1_uv_fast_code), 13'h00ff);
      u_svb_host.wr(8'h1f, 8'h01);
      cyc(2);
      chk(ch1_uv_fast_mv, 13'h170c);
      chk(13'(range_4x), 13'h0001);
      u_svb_host.wr(8'h1e, 8'h7f);
      u_svb_host.wr(8'h13, 8'h80);
      pulse(13);
      chk(13'(monitor_run), 13'h007f);
      pulse(0);
      cyc(2);
      chk(13'(interrupt_out_n), 13'h1);
      u_svb_host.wr(8'h1e, 8'hff);
      for (int k = 0; k < 13; k++) begin
         u_svb_host.wr(EV[k][23:16], EV[k][7:0]);
         act <= (k == 4);
         slp <= (k == 6);
         pulse(k);
         cyc(2);
         chk(13'(interrupt_out_n), 13'h1);
         u_svb_host.wr(EV[k][23:16], EV[k][15:8]);
         pulse(k);
         cyc(2);
         chk(13'(interrupt_out_n), 13'h0);
         u_svb_host.wr(EV[k][23:16], 8'h00);
         pulse(13);
         cyc(2);
         chk(13'(interrupt_out_n), 13'h1);
      end
      u_svb_host.wr(8'h12, 8'h08);
      u_svb_host.wr(8'h1c, 8'h01);
      act <= 1'b1;
      @(posedge clk);
      @(posedge clk);
      act <= 1'b0;
      cyc(1);
      chk(13'(selftest_start), 13'h1);
      chk(13'(selftest_ready), 13'h0);
      cyc(198);
      chk(13'(selftest_ready), 13'h0);
      cyc(4);
      chk(13'(selftest_ready), 13'h1);
      cyc(2);
      chk(13'(interrupt_out_n), 13'h1);
      u_svb_host.wr(8'h1c, 8'h02);
      cyc(2);
      chk(13'(interrupt_out_n), 13'h0);
      wrap_up();
   end
endmodule : tb_svb_bank
